// >>> include/cttm_pkg.sv
// Purpose: constants and carrier types of the compact timer with compare and PWM
// Assumes: 8-bit register port, one 100 MHz clock, fH taken equal to the system clock
// Notes: register map and flag register offsets are fixed here
// Function
// - low count register reads counter bits 7..0, read-only, resets to zero
// - high count register bits 1..0 read counter bits 9..8, resets zero
// - bits 7..2 of both high-byte registers always read zero
// - writable 10-bit compare-A value in low and high registers, reset zero
// - mode field: 00 compare-match, 11 timer/counter, 10 PWM
// - clear-source low: clear on period match or overflow; both flags raised
// - clear-source high: clear on compare-A match; period flag never set
// - clear-source high with compare-A zero: overflow at 3FF, no compare-A flag
// - compare mode: pin changes only on compare-A match or run rise, never period match
// - output action zero keeps pin level on compare-A match
// - outside PWM mode, counter-run rising edge loads pin with output-initial-level
// - timer/counter mode counts like compare mode, pin left unused
// - PWM mode ignores clear-source select; swap bit picks clearing register
// - PWM: one register sets period by clearing, other sets duty
// - PWM raises compare-A flag and period flag on their matches
// - PWM: initial level picks polarity, action enables or forces, invert reverses
// - swap zero: period 128 times code, code zero 1024, duty compare-A
// - duty equal or above period gives continuously active output
// - swap one: compare-A sets period, code sets duty in steps of 128
// - PWM counting and matching continue while output is forced
// - each PWM counter clear starts a new period
// - run rising resets counter; run falling stops and holds count
// - period code compares with bits 9..7 of the next count, with bits 6..0 zero
// - pause freezes the counter; release resumes from held value
// - compare mode actions 01 low, 10 high, 11 toggle on compare-A match
package cttm_pkg;

    localparam int CTTM_DATA_W = 8;
    localparam int CTTM_ADDR_W = 3;
    localparam int CTTM_CNT_W = 10;

    // register map, byte addresses on the 8-bit port
    localparam logic [2:0] CTTM_ADDR_CTRL0 = 3'h0;
    localparam logic [2:0] CTTM_ADDR_CTRL1 = 3'h1;
    localparam logic [2:0] CTTM_ADDR_COUNT_LOW = 3'h2;
    localparam logic [2:0] CTTM_ADDR_COUNT_HIGH = 3'h3;
    localparam logic [2:0] CTTM_ADDR_CMPA_LOW = 3'h4;
    localparam logic [2:0] CTTM_ADDR_CMPA_HIGH = 3'h5;
    localparam logic [2:0] CTTM_ADDR_FLAGS = 3'h6;

    localparam int CTTM_FLAG_A_BIT = 0;
    localparam int CTTM_FLAG_P_BIT = 1;
    localparam logic [7:0] CTTM_REG_RST = 8'h00;
    localparam logic [9:0] CTTM_CNT_RST = 10'h000;
    localparam logic [9:0] CTTM_CNT_MAX = 10'h3FF;
    localparam logic [10:0] CTTM_FULL_PERIOD = 11'h400;

    localparam logic [1:0] CTTM_MODE_CMP = 2'b00;
    localparam logic [1:0] CTTM_MODE_PWM = 2'b10;
    localparam logic [1:0] CTTM_MODE_TC = 2'b11;

    localparam logic [1:0] CTTM_ACT_NONE = 2'b00;
    localparam logic [1:0] CTTM_ACT_LOW = 2'b01;
    localparam logic [1:0] CTTM_ACT_HIGH = 2'b10;
    localparam logic [1:0] CTTM_ACT_TOGGLE = 2'b11;
    localparam logic [1:0] CTTM_PWM_INACTIVE = 2'b00;
    localparam logic [1:0] CTTM_PWM_ACTIVE = 2'b01;
    localparam logic [1:0] CTTM_PWM_WAVE = 2'b10;

    localparam logic [2:0] CTTM_CK_SYS_DIV4 = 3'h0;
    localparam logic [2:0] CTTM_CK_SYS = 3'h1;
    localparam logic [2:0] CTTM_CK_H_DIV16 = 3'h2;
    localparam logic [2:0] CTTM_CK_H_DIV64 = 3'h3;
    localparam logic [2:0] CTTM_CK_LIRC = 3'h4;
    localparam logic [2:0] CTTM_CK_PIN_RISE = 3'h6;
    localparam logic [2:0] CTTM_CK_PIN_FALL = 3'h7;

    localparam int CTTM_CLK_HZ = 100000000;
    localparam int CTTM_LIRC_HZ = 32000;
    localparam int CTTM_LIRC_DIV = CTTM_CLK_HZ / CTTM_LIRC_HZ;
    localparam logic [5:0] CTTM_PRE_RST = 6'h00;
    localparam logic [11:0] CTTM_LIRC_RST = 12'h000;

    typedef struct packed {
        logic counter_pause;
        logic [2:0] clock_select;
        logic counter_run;
        logic [2:0] period_code;
    } cttm_ctrl0_t;

    typedef struct packed {
        logic mode_select_high;
        logic mode_select_low;
        logic output_action_high;
        logic output_action_low;
        logic output_initial_level;
        logic output_invert;
        logic period_duty_swap;
        logic clear_source_select;
    } cttm_ctrl1_t;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } cttm_bus_req_t;

    typedef struct packed {
        logic out;
        logic oe;
    } cttm_pin_t;

endpackage

// >>> logic/cttm_timer.sv
// Purpose: compact 10-bit timer with compare-match output, timer/counter and PWM modes
// Assumes: single 100 MHz clock; timer clock comes as a one-cycle enable
// Notes: the external clock pin is synchronised by two flip-flops before use
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/1ps
module cttm_timer
    import cttm_pkg::*;
#(
    parameter int LIRC_DIV = CTTM_LIRC_DIV
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire cttm_bus_req_t bus_req,
    output logic [7:0] bus_rdata,
    input wire logic ext_clk_pin,
    output cttm_pin_t timer_pin,
    output logic compare_a_flag,
    output logic period_match_flag
);

    // ******************************
    // state
    // ******************************
    typedef struct packed {
        cttm_ctrl0_t ctrl0;
        cttm_ctrl1_t ctrl1;
        logic [9:0] cra;
        logic [9:0] cnt;
        logic flag_a;
        logic flag_p;
        logic run_prev;
        logic pin_raw;
        logic pin_drv;
        logic pin_oe;
        logic [5:0] pre;
        logic [11:0] lirc;
        logic ext_sync1;
        logic ext_sync2;
        logic ext_prev;
        logic [7:0] rdata;
    } cttm_state_t;

    localparam cttm_state_t CTTM_STATE_RST = '{
        ctrl0: CTTM_REG_RST,
        ctrl1: CTTM_REG_RST,
        cra: CTTM_CNT_RST,
        cnt: CTTM_CNT_RST,
        flag_a: 1'b0,
        flag_p: 1'b0,
        run_prev: 1'b0,
        pin_raw: 1'b0,
        pin_drv: 1'b0,
        pin_oe: 1'b1,
        pre: CTTM_PRE_RST,
        lirc: CTTM_LIRC_RST,
        ext_sync1: 1'b0,
        ext_sync2: 1'b0,
        ext_prev: 1'b0,
        rdata: CTTM_REG_RST
    };

    cttm_state_t st_reg;
    cttm_state_t st_next;

    // ******************************
    // helpers
    // ******************************
    // 3-bit code in steps of 128 clocks, code zero meaning the full 1024
    function automatic logic [10:0] code_span(input logic [2:0] code);
        logic [10:0] span;
        span = {1'b0, code, 7'h00};
        if (code == 3'h0) begin
            span = CTTM_FULL_PERIOD;
        end
        return span;
    endfunction

    logic [1:0] mode;
    logic [1:0] action;
    logic is_pwm;
    logic tick;
    logic run_rise;
    logic counting;
    logic [9:0] cnt_inc;
    logic overflow;
    logic a_hit;
    logic p_hit;
    logic clear_on_a;
    logic clear_hit;
    logic p_enable;
    logic a_evt;
    logic p_evt;
    logic [10:0] duty_val;
    logic pwm_active;
    logic wave_on;
    logic flag_w1c;

    // ******************************
    // next state
    // ******************************
    always_comb begin
        st_next = st_reg;
        mode = {st_reg.ctrl1.mode_select_high, st_reg.ctrl1.mode_select_low};
        action = {st_reg.ctrl1.output_action_high, st_reg.ctrl1.output_action_low};
        is_pwm = (mode == CTTM_MODE_PWM);

        // prescaler and external pin synchroniser
        st_next.pre = st_reg.pre + 6'h01;
        st_next.lirc = st_reg.lirc + 12'h001;
        if (st_reg.lirc == 12'(LIRC_DIV - 1)) begin
            st_next.lirc = CTTM_LIRC_RST;
        end
        st_next.ext_sync1 = ext_clk_pin;
        st_next.ext_sync2 = st_reg.ext_sync1;
        st_next.ext_prev = st_reg.ext_sync2;
        case (st_reg.ctrl0.clock_select)
            CTTM_CK_SYS_DIV4: tick = (st_reg.pre[1:0] == 2'h3);
            CTTM_CK_SYS: tick = 1'b1;
            CTTM_CK_H_DIV16: tick = (st_reg.pre[3:0] == 4'hF);
            CTTM_CK_H_DIV64: tick = (st_reg.pre == 6'h3F);
            CTTM_CK_LIRC: tick = (st_reg.lirc == 12'(LIRC_DIV - 1));
            CTTM_CK_PIN_RISE: tick = st_reg.ext_sync2 & ~st_reg.ext_prev;
            CTTM_CK_PIN_FALL: tick = ~st_reg.ext_sync2 & st_reg.ext_prev;
            default: tick = 1'b0;
        endcase

        // comparators
        run_rise = st_reg.ctrl0.counter_run & ~st_reg.run_prev;
        st_next.run_prev = st_reg.ctrl0.counter_run;
        counting = st_reg.ctrl0.counter_run & ~st_reg.ctrl0.counter_pause & tick;
        cnt_inc = st_reg.cnt + 10'h001;
        overflow = (st_reg.cnt == CTTM_CNT_MAX);
        a_hit = (st_reg.cra != CTTM_CNT_RST) && (cnt_inc == st_reg.cra);
        if (st_reg.ctrl0.period_code == 3'h0) begin
            p_hit = overflow;
        end else begin
            p_hit = (cnt_inc[9:7] == st_reg.ctrl0.period_code) && (cnt_inc[6:0] == 7'h00);
        end
        if (is_pwm) begin
            clear_on_a = st_reg.ctrl1.period_duty_swap;
        end else begin
            clear_on_a = st_reg.ctrl1.clear_source_select;
        end
        clear_hit = clear_on_a ? a_hit : p_hit;
        p_enable = is_pwm | ~st_reg.ctrl1.clear_source_select;
        a_evt = counting & a_hit & ~run_rise;
        p_evt = counting & p_hit & p_enable & ~run_rise;

        // counter: overflow wraps through the 10-bit add
        if (run_rise) begin
            st_next.cnt = CTTM_CNT_RST;
        end else if (counting) begin
            st_next.cnt = clear_hit ? CTTM_CNT_RST : cnt_inc;
        end

        // flags, a set in the clearing cycle wins
        flag_w1c = bus_req.wr && (bus_req.addr == CTTM_ADDR_FLAGS);
        st_next.flag_a = (st_reg.flag_a & ~(flag_w1c & bus_req.wdata[CTTM_FLAG_A_BIT])) | a_evt;
        st_next.flag_p = (st_reg.flag_p & ~(flag_w1c & bus_req.wdata[CTTM_FLAG_P_BIT])) | p_evt;

        // PWM waveform: active from clear until the duty match
        if (st_reg.ctrl1.period_duty_swap) begin
            duty_val = code_span(st_reg.ctrl0.period_code);
        end else begin
            duty_val = {1'b0, st_reg.cra};
        end
        pwm_active = ({1'b0, st_next.cnt} < duty_val);
        case (action)
            CTTM_PWM_INACTIVE: wave_on = 1'b0;
            CTTM_PWM_ACTIVE: wave_on = 1'b1;
            CTTM_PWM_WAVE: wave_on = pwm_active;
            default: wave_on = 1'b0;
        endcase

        // output pin
        if (is_pwm) begin
            st_next.pin_raw = wave_on ? st_reg.ctrl1.output_initial_level
                                      : ~st_reg.ctrl1.output_initial_level;
        end else if (run_rise) begin
            st_next.pin_raw = st_reg.ctrl1.output_initial_level;
        end else if (a_evt) begin
            case (action)
                CTTM_ACT_NONE: st_next.pin_raw = st_reg.pin_raw;
                CTTM_ACT_LOW: st_next.pin_raw = 1'b0;
                CTTM_ACT_HIGH: st_next.pin_raw = 1'b1;
                default: st_next.pin_raw = ~st_reg.pin_raw;
            endcase
        end
        st_next.pin_drv = st_next.pin_raw ^ st_reg.ctrl1.output_invert;
        st_next.pin_oe = (mode != CTTM_MODE_TC);

        // register writes
        if (bus_req.wr) begin
            if (bus_req.addr == CTTM_ADDR_CTRL0) begin
                st_next.ctrl0 = bus_req.wdata;
            end else if (bus_req.addr == CTTM_ADDR_CTRL1) begin
                st_next.ctrl1 = bus_req.wdata;
            end else if (bus_req.addr == CTTM_ADDR_CMPA_LOW) begin
                st_next.cra[7:0] = bus_req.wdata;
            end else if (bus_req.addr == CTTM_ADDR_CMPA_HIGH) begin
                st_next.cra[9:8] = bus_req.wdata[1:0];
            end
        end

        // register reads, data valid only in the following cycle
        st_next.rdata = CTTM_REG_RST;
        if (bus_req.rd) begin
            if (bus_req.addr == CTTM_ADDR_CTRL0) begin
                st_next.rdata = st_reg.ctrl0;
            end else if (bus_req.addr == CTTM_ADDR_CTRL1) begin
                st_next.rdata = st_reg.ctrl1;
            end else if (bus_req.addr == CTTM_ADDR_COUNT_LOW) begin
                st_next.rdata = st_reg.cnt[7:0];
            end else if (bus_req.addr == CTTM_ADDR_COUNT_HIGH) begin
                st_next.rdata = {6'h00, st_reg.cnt[9:8]};
            end else if (bus_req.addr == CTTM_ADDR_CMPA_LOW) begin
                st_next.rdata = st_reg.cra[7:0];
            end else if (bus_req.addr == CTTM_ADDR_CMPA_HIGH) begin
                st_next.rdata = {6'h00, st_reg.cra[9:8]};
            end else if (bus_req.addr == CTTM_ADDR_FLAGS) begin
                st_next.rdata = {6'h00, st_reg.flag_p, st_reg.flag_a};
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg <= CTTM_STATE_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // ******************************
    // outputs
    // ******************************
    assign bus_rdata = st_reg.rdata;
    assign timer_pin.out = st_reg.pin_drv;
    assign timer_pin.oe = st_reg.pin_oe;
    assign compare_a_flag = st_reg.flag_a;
    assign period_match_flag = st_reg.flag_p;

    // ******************************
    // checks
    // ******************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence run_rise_s;
        st_reg.ctrl0.counter_run && !st_reg.run_prev;
    endsequence

    sequence low_read_s;
        bus_req.rd && bus_req.addr == CTTM_ADDR_COUNT_LOW;
    endsequence

    count_low_read_a: assert property (
        low_read_s |=> bus_rdata == $past(st_reg.cnt[7:0]))
        else $error("count low read mismatch");

    count_high_read_a: assert property (
        bus_req.rd && bus_req.addr == CTTM_ADDR_COUNT_HIGH
        |=> bus_rdata == {6'h00, $past(st_reg.cnt[9:8])})
        else $error("count high read mismatch");

    run_rise_clear_a: assert property (
        run_rise_s |=> st_reg.cnt == CTTM_CNT_RST)
        else $error("counter not cleared on run rise");

    run_off_hold_a: assert property (
        !st_reg.ctrl0.counter_run ##1 !st_reg.ctrl0.counter_run |-> $stable(st_reg.cnt))
        else $error("counter moved while stopped");

    pause_freeze_a: assert property (
        st_reg.ctrl0.counter_pause && st_reg.run_prev && st_reg.ctrl0.counter_run
        |=> st_reg.cnt == $past(st_reg.cnt))
        else $error("counter moved while paused");

    no_period_flag_a: assert property (
        !is_pwm && st_reg.ctrl1.clear_source_select && !st_reg.flag_p
        |=> !st_reg.flag_p)
        else $error("period flag set with compare-A clear");

    flag_set_wins_a: assert property (
        a_evt |=> st_reg.flag_a)
        else $error("compare-A event lost");

    pin_quiet_a: assert property (
        mode == CTTM_MODE_CMP && !a_evt && !run_rise && !bus_req.wr
        |=> st_reg.pin_raw == $past(st_reg.pin_raw))
        else $error("compare pin changed without compare-A match");

    action_toggle_a: assert property (
        mode == CTTM_MODE_CMP && a_evt && action == CTTM_ACT_TOGGLE && !run_rise
        |=> st_reg.pin_raw != $past(st_reg.pin_raw))
        else $error("toggle action did not toggle");

    full_duty_a: assert property (
        is_pwm && action == CTTM_PWM_WAVE && !bus_req.wr
        && !st_reg.ctrl1.period_duty_swap && st_reg.ctrl0.period_code == 3'h1
        && st_reg.cra >= 10'h080 && st_reg.cnt < 10'h080
        |=> st_reg.pin_raw == $past(st_reg.ctrl1.output_initial_level))
        else $error("full duty output not active");

    timer_mode_pin_a: assert property (
        mode == CTTM_MODE_TC && !bus_req.wr |=> !timer_pin.oe)
        else $error("pin driven in timer mode");

    cmpa_high_read_a: assert property (
        bus_req.rd && bus_req.addr == CTTM_ADDR_CMPA_HIGH |=> bus_rdata[7:2] == 6'h00)
        else $error("compare-A high unused bits not zero");

    period_flag_set_a: assert property (
        !is_pwm && !st_reg.ctrl1.clear_source_select && counting && p_hit && !run_rise
        |=> st_reg.flag_p)
        else $error("period flag not raised on period match");

    run_rise_pin_a: assert property (
        run_rise_s && !is_pwm |=> st_reg.pin_raw == $past(st_reg.ctrl1.output_initial_level))
        else $error("pin not loaded with initial level on run rise");

    pwm_clear_a: assert property (
        is_pwm && counting && clear_hit && !run_rise |=> st_reg.cnt == CTTM_CNT_RST)
        else $error("pwm period did not restart on clear");

    overflow_wrap_a: assert property (
        counting && overflow && !run_rise |=> st_reg.cnt == CTTM_CNT_RST)
        else $error("counter did not wrap at maximum");

    zero_a_silent_a: assert property (
        st_reg.cra == CTTM_CNT_RST |-> !a_evt)
        else $error("compare-A event with zero compare value");

    action_none_a: assert property (
        mode == CTTM_MODE_CMP && a_evt && action == CTTM_ACT_NONE && !run_rise
        |=> st_reg.pin_raw == $past(st_reg.pin_raw))
        else $error("no-change action moved the pin");

    forced_pin_a: assert property (
        is_pwm && action == CTTM_PWM_ACTIVE |=> st_reg.pin_raw == $past(st_reg.ctrl1.output_initial_level))
        else $error("forced active pwm level wrong");

endmodule

// >>> tb/compact_timer_compare_pwm_tb_top.sv
// Purpose: self-checking bench of the compact timer
// Assumes: timer clock select 1, one tick per clk, except in the clock-rate scenarios
// Notes: pwm duty is judged by the pin load over whole periods
`timescale 1ns/1ps
module compact_timer_compare_pwm_tb_top
    import cttm_pkg::*;
;
    logic clk;
    logic sys_rst;
    cttm_bus_req_t bus_req;
    logic [7:0] bus_rdata;
    logic ext_clk_pin = 1'b0;
    cttm_pin_t timer_pin;
    logic compare_a_flag;
    logic period_match_flag;
    logic meas_clear;
    logic [15:0] high_count;
    int num_errors;
    int check_count;
    int cyc;

    cttm_timer #(.LIRC_DIV(4)) dut (.clk(clk), .sys_rst(sys_rst), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .ext_clk_pin(ext_clk_pin), .timer_pin(timer_pin),
        .compare_a_flag(compare_a_flag), .period_match_flag(period_match_flag));
    cttm_pin_load load (.clk(clk), .sys_rst(sys_rst), .timer_pin(timer_pin),
        .meas_clear(meas_clear), .high_count(high_count));

    // ***********
    // bus helpers
    // ***********
    task automatic conclude();
        if (num_errors == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus_req <= '0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        bus_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        bus_req <= '0;
        #1;
        d = bus_rdata;
    endtask
    task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk({8'h00, d}, {8'h00, exp});
    endtask
    task automatic start(input logic [7:0] c1, input logic [7:0] c0);
        wr(CTTM_ADDR_CTRL0, c0);
        wr(CTTM_ADDR_CTRL1, c1);
        wr(CTTM_ADDR_CTRL0, c0 | 8'h08);
        wr(CTTM_ADDR_FLAGS, 8'h03);
        #1;
    endtask
    task automatic wait_flag(input logic is_p, output int t);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while ((is_p ? period_match_flag : compare_a_flag) !== 1'b1 && n < 3000);
        if (n >= 3000) begin
            num_errors++;
            $display("[ERR] %0t flag never rose", $time);
        end
        t = cyc;
    endtask
    task automatic set_a(input logic [9:0] a);
        wr(CTTM_ADDR_CMPA_LOW, a[7:0]);
        wr(CTTM_ADDR_CMPA_HIGH, {6'h00, a[9:8]});
    endtask

    // *********
    // scenarios
    // *********
    task automatic t_regs();
        rdchk(CTTM_ADDR_COUNT_LOW, 8'h00);
        rdchk(CTTM_ADDR_COUNT_HIGH, 8'h00);
        rdchk(CTTM_ADDR_CMPA_LOW, 8'h00);
        rdchk(CTTM_ADDR_CMPA_HIGH, 8'h00);
        wr(CTTM_ADDR_CMPA_LOW, 8'hA5);
        wr(CTTM_ADDR_CMPA_HIGH, 8'hFF);
        rdchk(CTTM_ADDR_CMPA_LOW, 8'hA5);
        rdchk(CTTM_ADDR_CMPA_HIGH, 8'h03);
        wr(CTTM_ADDR_COUNT_LOW, 8'h55);
        wr(CTTM_ADDR_COUNT_HIGH, 8'hFF);
        rdchk(CTTM_ADDR_COUNT_LOW, 8'h00);
        rdchk(CTTM_ADDR_COUNT_HIGH, 8'h00);
        rdchk(3'h7, 8'h00);
    endtask
    task automatic t_clear_a();
        int t1;
        int t2;
        set_a(10'h105);
        start(8'h39, 8'h11);
        chk(timer_pin.out, 16'h1);
        wait_flag(1'b0, t1);
        chk(timer_pin.out, 16'h0);
        wr(CTTM_ADDR_FLAGS, 8'h03);
        wait_flag(1'b0, t2);
        chk(t2 - t1, 16'd261);
        chk(timer_pin.out, 16'h1);
        chk(period_match_flag, 16'h0);
        rdchk(CTTM_ADDR_FLAGS, 8'h01);
    endtask
    task automatic clk_rate(input logic [2:0] sel, input logic [15:0] span);
        int t1;
        int t2;
        start(8'h00, {1'b0, sel, 4'h1});
        wait_flag(1'b1, t1);
        wr(CTTM_ADDR_FLAGS, 8'h03);
        wait_flag(1'b1, t2);
        chk(t2 - t1, span);
    endtask
    task automatic t_clocks();
        clk_rate(CTTM_CK_SYS_DIV4, 16'd512);
        clk_rate(CTTM_CK_H_DIV16, 16'd2048);
        clk_rate(CTTM_CK_LIRC, 16'd512);
        clk_rate(CTTM_CK_PIN_RISE, 16'd256);
        clk_rate(CTTM_CK_PIN_FALL, 16'd256);
    endtask
    task automatic t_actions();
        int t1;
        int t2;
        int t3;
        logic [1:0] act;
        logic exp;
        set_a(10'd20);
        for (int i = 0; i < 4; i++) begin
            act = i[1:0];
            start({2'b00, act, ~act[1], 3'b000}, 8'h11);
            chk(timer_pin.out, {15'h0, ~act[1]});
            exp = (act == 2'b00) ? ~act[1] : (act == 2'b11) ? act[1] : act[1];
            wait_flag(1'b0, t1);
            chk(timer_pin.out, {15'h0, exp});
            wait_flag(1'b1, t2);
            chk(t2 - t1, 16'd108);
            chk(timer_pin.out, {15'h0, exp});
            chk(compare_a_flag, 16'h1);
            wr(CTTM_ADDR_FLAGS, 8'h03);
            wait_flag(1'b1, t3);
            chk(t3 - t2, 16'd128);
        end
    endtask
    task automatic t_timer_counter();
        int t1;
        start(8'hC0, 8'h11);
        chk(timer_pin.oe, 16'h0);
        wait_flag(1'b1, t1);
        chk(compare_a_flag, 16'h1);
    endtask
    task automatic t_overflow_pause();
        logic [7:0] v1;
        logic [7:0] v2;
        logic [7:0] v3;
        set_a(10'h000);
        start(8'h01, 8'h10);
        repeat (1100) @(posedge clk);
        chk(compare_a_flag, 16'h0);
        rdchk(CTTM_ADDR_COUNT_HIGH, 8'h00);
        wr(CTTM_ADDR_CTRL0, 8'h98);
        rd(CTTM_ADDR_COUNT_LOW, v1);
        repeat (20) @(posedge clk);
        rdchk(CTTM_ADDR_COUNT_LOW, v1);
        wr(CTTM_ADDR_CTRL0, 8'h18);
        repeat (10) @(posedge clk);
        rd(CTTM_ADDR_COUNT_LOW, v2);
        chk({15'h0, v2 > v1}, 16'h1);
        wr(CTTM_ADDR_CTRL0, 8'h10);
        rd(CTTM_ADDR_COUNT_LOW, v3);
        repeat (20) @(posedge clk);
        rdchk(CTTM_ADDR_COUNT_LOW, v3);
        wr(CTTM_ADDR_CTRL0, 8'h18);
        rd(CTTM_ADDR_COUNT_LOW, v3);
        chk({15'h0, v3 < 8'h08}, 16'h1);
    endtask
    // measure pin-high cycles over a window of whole pwm periods
    task automatic pwm(input logic [7:0] c1, input logic [2:0] code, input logic [9:0] a,
                       input int win, input logic [15:0] exp);
        set_a(a);
        start(c1, {5'h02, code});
        repeat (4) @(posedge clk);
        meas_clear <= 1'b1;
        @(posedge clk);
        meas_clear <= 1'b0;
        repeat (win) @(posedge clk);
        #1;
        chk(high_count, exp);
    endtask
    task automatic t_pwm();
        int t1;
        int t2;
        pwm(8'hA8, 3'h1, 10'd32, 256, 16'd64);
        pwm(8'hAC, 3'h1, 10'd32, 256, 16'd192);
        pwm(8'hA0, 3'h1, 10'd32, 256, 16'd192);
        pwm(8'hA9, 3'h1, 10'd32, 256, 16'd64);
        pwm(8'hA8, 3'h1, 10'd200, 256, 16'd256);
        pwm(8'hAA, 3'h1, 10'd200, 400, 16'd256);
        pwm(8'h98, 3'h1, 10'd32, 256, 16'd256);
        pwm(8'h88, 3'h1, 10'd32, 256, 16'd0);
        wr(CTTM_ADDR_FLAGS, 8'h03);
        wait_flag(1'b1, t1);
        wr(CTTM_ADDR_FLAGS, 8'h03);
        wait_flag(1'b1, t2);
        chk(t2 - t1, 16'd128);
        chk(compare_a_flag, 16'h1);
    endtask

    // ****
    // main
    // ****
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
    end
    // external timer clock: one rising edge every two clk cycles
    always @(posedge clk) begin
        ext_clk_pin <= ~ext_clk_pin & ~sys_rst;
    end
    initial begin
        repeat (30000) @(posedge clk);
        num_errors++;
        conclude();
    end
    initial begin
        sys_rst = 1'b1;
        bus_req = '0;
        meas_clear = 1'b0;
        num_errors = 0;
        check_count = 0;
        cyc = 0;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        t_regs();
        t_clear_a();
        t_actions();
        t_timer_counter();
        t_overflow_pause();
        t_pwm();
        t_clocks();
        conclude();
    end
endmodule

// >>> tb/cttm_pin_load.sv
// Purpose: load on the timer output pin that tallies driven-high cycles
// Assumes: pin sampled on the rising clock edge
// Notes: an undriven pin reads as pulled low
`timescale 1ns/1ps
module cttm_pin_load
    import cttm_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire cttm_pin_t timer_pin,
    input wire logic meas_clear,
    output logic [15:0] high_count
);
    // ****************
    // high-level tally
    // ****************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            high_count <= 16'h0000;
        end else if (meas_clear) begin
            high_count <= 16'h0000;
        end else if (timer_pin.oe && timer_pin.out) begin
            high_count <= high_count + 16'h0001;
        end
    end
endmodule
